/* tsf_pkg.sv */
// constants, types and the error-code helper for the task-switch fault checker
// assumes a single core clock; shared by the checker and the descriptor judge
package tsf_pkg;

  // vector numbers of the two faults and of the escalation
  localparam logic [7:0]  VEC_INVALID_TASK = 8'h0a;
  localparam logic [7:0]  VEC_SEG_ABSENT   = 8'h0b;
  localparam logic [7:0]  VEC_DOUBLE       = 8'h08;

  // least legal limit of a task-state record
  localparam logic [31:0] MIN_RECORD_LIMIT = 32'h0000_0067;

  // error-code field positions
  localparam int          CODE_EXT_BIT     = 0;
  localparam int          CODE_IDT_BIT     = 1;
  localparam int          CODE_TI_BIT      = 2;
  localparam int          CODE_INDEX_LSB   = 3;
  localparam int          SEL_TI_BIT       = 2;

  // values after reset
  localparam logic [15:0] CODE_RST         = 16'h0000;
  localparam logic [31:0] IP_RST           = 32'h0000_0000;
  localparam logic [7:0]  VEC_RST          = 8'h00;

  // segment registers checked during a switch
  typedef enum logic [1:0] {SEG_LOCAL_TABLE, SEG_STACK, SEG_CODE, SEG_DATA} seg_kind_e;

  // single register loads or gate uses outside a switch
  typedef enum logic [2:0] {LD_CODE, LD_DATA, LD_STACK, LD_LOCAL_TABLE,
                            LD_TASK_REG, LD_GATE} load_kind_e;

  // outcome of one descriptor check
  typedef enum logic [1:0] {VIOL_NONE, VIOL_TASK_STATE, VIOL_ABSENT, VIOL_STACK} viol_e;

  // class of the exception being delivered when a new one arises
  typedef enum logic [1:0] {CLS_BENIGN, CLS_CONTRIB, CLS_PAGE} exc_class_e;

  // error code: index, table indicator, vector-table flag, external flag
  function automatic logic [15:0] make_error_code(input logic [15:0] sel,
                                                  input logic external_event_flag,
                                                  input logic interrupt_vector_table);
    logic [15:0] c;
    c = CODE_RST;
    c[15:CODE_INDEX_LSB] = sel[15:CODE_INDEX_LSB];
    c[CODE_TI_BIT]       = sel[SEL_TI_BIT];
    c[CODE_IDT_BIT]      = interrupt_vector_table;
    c[CODE_EXT_BIT]      = external_event_flag;
    return c;
  endfunction

endpackage

/* seg_descriptor_checker.sv */
// judges one segment descriptor loaded from an incoming task-state record
// assumes descriptor flags come from the table walker on the same clock
module seg_descriptor_checker
  import tsf_pkg::*;
(
  input  wire logic            i_check_en,   // checking still active
  input  wire tsf_pkg::seg_kind_e i_kind,    // which register
  input  wire logic [1:0]      i_rpl,        // requested privilege of selector
  input  wire logic [1:0]      i_dpl,        // descriptor privilege
  input  wire logic [1:0]      i_cpl,        // current privilege
  input  wire logic            i_over_limit, // selector beyond table limit
  input  wire logic            i_present,    // present flag
  input  wire logic            i_table_ok,   // local table descriptor valid
  input  wire logic            i_writable,   // writable data segment
  input  wire logic            i_readable,   // readable segment
  input  wire logic            i_exec,       // executable segment
  input  wire logic            i_conforming, // conforming code segment
  output tsf_pkg::viol_e       o_viol        // verdict
);

  // invalid-record conditions per register kind
  wire ldt_bad  = !i_table_ok || !i_present;
  wire ss_bad   = i_over_limit || !i_writable
                  || (i_dpl != i_cpl) || (i_rpl != i_cpl);
  wire cs_priv  = i_conforming ? (i_dpl > i_cpl) : (i_dpl != i_cpl);
  wire cs_bad   = i_over_limit || !i_exec || cs_priv;
  wire ds_bad   = i_over_limit || !i_readable;

  // absent stack is handed to the stack fault, code and data become absent faults
  wire [1:0] sel_kind = i_kind;
  wire       is_ldt   = (sel_kind == 2'(SEG_LOCAL_TABLE));
  wire       is_ss    = (sel_kind == 2'(SEG_STACK));
  wire       is_cs    = (sel_kind == 2'(SEG_CODE));
  wire       bad      = is_ldt ? ldt_bad : is_ss ? ss_bad : is_cs ? cs_bad : ds_bad;

  // type checks take precedence over presence: absent means otherwise valid
  assign o_viol = !i_check_en ? VIOL_NONE
                : bad         ? VIOL_TASK_STATE
                : !i_present  ? (is_ss ? VIOL_STACK : VIOL_ABSENT)
                : VIOL_NONE;

endmodule

/* task_switch_segment_fault_checker.sv */
// fault logic for task switches and segment-register loads
// assumes the switch sequencer and table walker run on i_core_clk
// Function
// - record limit below 67h raises invalid-task-state with record selector
// - invalid or absent local table raises invalid-task-state with its selector
// - bad stack selector limit, writability or privilege raises invalid-task-state
// - bad code selector limit, type or privilege raises invalid-task-state
// - data selector over limit or unreadable raises invalid-task-state
// - invalid-task-state is a fault on vector ten
// - segment-absent is a fault on vector eleven
// - before record presence is verified, faults use old task context
// - commit once task register holds new selector and link set if needed
// - error code carries selector index and external-event flag
// - pre-switch fault saves invoking pointer, post-switch saves new first pointer
// - pre-commit fault changes nothing; post-commit fault waits for full load
// - load all segment registers, stop checking after first violation
// - after commit, load rest without more checks before raising absent fault
// - clear present flag on code, data, table, task or gate raises absent
// - absent stack goes to stack fault; absent table in switch is invalid-task
// - absent fault code sets external flag and vector-table flag as needed
// - absent fault saves faulting, new-task-first or gate-invoking pointer
// - register load still writes on absent fault; gate access writes nothing
// - both faults contributory; over prior contributory or page gives double
module task_switch_segment_fault_checker
  import tsf_pkg::*;
(
  input  wire logic               i_core_clk,       // core clock, 25 MHz
  input  wire logic               i_reset_n,        // synchronous reset
  input  wire logic               i_ts_start,       // task switch begins
  input  wire logic [15:0]        i_ts_sel,         // new record selector
  input  wire logic [31:0]        i_ts_limit,       // new record limit
  input  wire logic               i_ts_present,     // new record present
  input  wire logic               i_ts_ext,         // switch from external event
  input  wire logic               i_ts_link_req,    // call or interrupt switch
  input  wire logic [31:0]        i_old_ip,         // invoking instruction
  input  wire logic [31:0]        i_new_ip,         // new task first instruction
  input  wire logic               i_tr_loaded,      // task pointer holds new sel
  input  wire logic               i_link_ok,        // link field set to old
  input  wire logic               i_seg_valid,      // segment register loaded
  input  wire logic               i_seg_last,       // last one of the switch
  input  wire tsf_pkg::seg_kind_e i_seg_kind,       // which register
  input  wire logic [15:0]        i_seg_sel,        // selector from record
  input  wire logic               i_seg_over_limit, // beyond table limit
  input  wire logic               i_seg_present,    // present flag
  input  wire logic               i_seg_table_ok,   // local table valid
  input  wire logic               i_seg_writable,   // writable segment
  input  wire logic               i_seg_readable,   // readable segment
  input  wire logic               i_seg_exec,       // executable segment
  input  wire logic               i_seg_conforming, // conforming code
  input  wire logic [1:0]         i_seg_dpl,        // descriptor privilege
  input  wire logic [1:0]         i_cpl,            // current privilege
  input  wire logic               i_ld_valid,       // single load or gate use
  input  wire tsf_pkg::load_kind_e i_ld_kind,       // target of the load
  input  wire logic [15:0]        i_ld_sel,         // selector loaded
  input  wire logic               i_ld_present,     // present flag
  input  wire logic               i_ld_ext,         // from NMI or interrupt
  input  wire logic               i_ld_idt,         // refers to vector table
  input  wire logic [31:0]        i_ld_ip,          // faulting/invoking pointer
  input  wire logic               i_delivering,     // prior exception in flight
  input  wire tsf_pkg::exc_class_e i_prior_class,   // class of prior exception
  output logic                    o_fault_valid,    // fault raised, pulse
  output logic [7:0]              o_fault_vector,   // vector number
  output logic [15:0]             o_fault_code,     // error code to push
  output logic [31:0]             o_fault_ip,       // saved pointer
  output logic                    o_fault_new_ctx,  // raised in new task
  output logic                    o_double_fault,   // escalated, pulse
  output logic                    o_stack_handoff,  // absent stack, pulse
  output logic                    o_committed,      // commit point reached
  output logic                    o_seg_load_en,    // write segment register
  output logic                    o_check_active,   // checks still applied
  output logic                    o_ld_write,       // single load writes reg
  output logic                    o_busy            // switch in progress
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_COMMIT, ST_LOAD} state_e;

  state_e       state_q, state_d;
  viol_e        pend_q, pend_d;
  logic [15:0]  pend_sel_q, pend_sel_d;
  logic         ext_q;
  logic         link_req_q;
  logic [31:0]  new_ip_q;
  logic         valid_q, dbl_q, stack_q, new_ctx_q;
  logic [7:0]   vec_q;
  logic [15:0]  code_q;
  logic [31:0]  ip_q;

  // raise request formed by the sequencing logic below
  viol_e        rs_kind;
  logic [15:0]  rs_sel;
  logic         rs_ext;
  logic         rs_idt;
  logic [31:0]  rs_ip;
  logic         rs_new;
  viol_e        seg_viol;

  // checks stop at the first violation, loads carry on
  wire check_on   = (state_q == ST_LOAD) && (pend_q == VIOL_NONE);

  seg_descriptor_checker u_check (
    .i_check_en   (check_on),
    .i_kind       (i_seg_kind),
    .i_rpl        (i_seg_sel[1:0]),
    .i_dpl        (i_seg_dpl),
    .i_cpl        (i_cpl),
    .i_over_limit (i_seg_over_limit),
    .i_present    (i_seg_present),
    .i_table_ok   (i_seg_table_ok),
    .i_writable   (i_seg_writable),
    .i_readable   (i_seg_readable),
    .i_exec       (i_seg_exec),
    .i_conforming (i_seg_conforming),
    .o_viol       (seg_viol)
  );

  // record checks at switch start and single-load presence decode
  wire limit_short = (i_ts_limit < MIN_RECORD_LIMIT);
  wire ld_is_gate  = (i_ld_kind == LD_GATE);
  wire ld_is_stack = (i_ld_kind == LD_STACK);
  wire ld_take     = (state_q == ST_IDLE) && !i_ts_start && i_ld_valid;
  wire commit_now  = (state_q == ST_WAIT_COMMIT) && i_tr_loaded
                     && (!link_req_q || i_link_ok);

  // next state and the single raise point of the block
  always_comb
  begin
    state_d    = state_q;
    pend_d     = pend_q;
    pend_sel_d = pend_sel_q;
    rs_kind    = VIOL_NONE;
    rs_sel     = CODE_RST;
    rs_ext     = 1'b0;
    rs_idt     = 1'b0;
    rs_ip      = i_old_ip;
    rs_new     = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (i_ts_start)
        begin
          rs_sel = i_ts_sel;
          rs_ext = i_ts_ext;
          // before commit the old context and invoking pointer are used
          if (limit_short)
            rs_kind = VIOL_TASK_STATE;
          else if (!i_ts_present)
            rs_kind = VIOL_ABSENT;
          else
            state_d = ST_WAIT_COMMIT;
        end
        else if (ld_take && !i_ld_present)
        begin
          rs_kind = ld_is_stack ? VIOL_STACK : VIOL_ABSENT;
          rs_sel  = i_ld_sel;
          rs_ext  = i_ld_ext;
          rs_idt  = i_ld_idt;
          rs_ip   = i_ld_ip;
        end
      end
      ST_WAIT_COMMIT:
      begin
        if (commit_now)
        begin
          state_d = ST_LOAD;
          pend_d  = VIOL_NONE;
        end
      end
      ST_LOAD:
      begin
        if (i_seg_valid)
        begin
          if (seg_viol != VIOL_NONE)
          begin
            pend_d     = seg_viol;
            pend_sel_d = i_seg_sel;
          end
          // the fault waits until every register has been loaded
          if (i_seg_last)
          begin
            rs_kind = (seg_viol != VIOL_NONE) ? seg_viol : pend_q;
            rs_sel  = (seg_viol != VIOL_NONE) ? i_seg_sel : pend_sel_q;
            rs_ext  = ext_q;
            rs_ip   = new_ip_q;
            rs_new  = 1'b1;
            state_d = ST_IDLE;
          end
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // vector choice and escalation over a prior contributory or page fault
  wire raise_any = (rs_kind == VIOL_TASK_STATE) || (rs_kind == VIOL_ABSENT);
  wire raise_dbl = raise_any && i_delivering && (i_prior_class != CLS_BENIGN);
  wire [7:0]  vec_d  = raise_dbl ? VEC_DOUBLE
                     : (rs_kind == VIOL_TASK_STATE) ? VEC_INVALID_TASK
                     : VEC_SEG_ABSENT;
  wire [15:0] code_d = raise_dbl ? CODE_RST
                     : make_error_code(rs_sel, rs_ext, rs_idt);
  wire        hold_d = raise_any || (rs_kind == VIOL_STACK);

  // control state
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      state_q    <= ST_IDLE;
      pend_q     <= VIOL_NONE;
      pend_sel_q <= CODE_RST;
    end
    else
    begin
      state_q    <= state_d;
      pend_q     <= pend_d;
      pend_sel_q <= pend_sel_d;
    end
  end

  // switch context captured at start, reused for post-commit faults
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      ext_q      <= 1'b0;
      link_req_q <= 1'b0;
      new_ip_q   <= IP_RST;
    end
    else if (state_q == ST_IDLE && i_ts_start)
    begin
      ext_q      <= i_ts_ext;
      link_req_q <= i_ts_link_req;
      new_ip_q   <= i_new_ip;
    end
  end

  // fault report registers; data stands until the next raise or stack handoff
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      valid_q   <= 1'b0;
      dbl_q     <= 1'b0;
      stack_q   <= 1'b0;
      vec_q     <= VEC_RST;
      code_q    <= CODE_RST;
      ip_q      <= IP_RST;
      new_ctx_q <= 1'b0;
    end
    else
    begin
      valid_q <= raise_any;
      dbl_q   <= raise_dbl;
      stack_q <= (rs_kind == VIOL_STACK);
      if (hold_d)
      begin
        vec_q     <= vec_d;
        code_q    <= code_d;
        ip_q      <= rs_ip;
        new_ctx_q <= rs_new;
      end
    end
  end

  // handshakes; a gate access never writes, a register load always does when taken in idle
  assign o_committed     = commit_now;
  assign o_seg_load_en   = (state_q == ST_LOAD) && i_seg_valid;
  assign o_check_active  = check_on;
  assign o_ld_write      = ld_take && !ld_is_gate;
  assign o_busy          = (state_q != ST_IDLE);
  assign o_fault_valid   = valid_q;
  assign o_fault_vector  = vec_q;
  assign o_fault_code    = code_q;
  assign o_fault_ip      = ip_q;
  assign o_fault_new_ctx = new_ctx_q;
  assign o_double_fault  = dbl_q;
  assign o_stack_handoff = stack_q;

  property p_short_record;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == ST_IDLE && i_ts_start && limit_short && !i_delivering)
    |=> o_fault_valid && o_fault_vector == VEC_INVALID_TASK
        && o_fault_code[15:3] == $past(i_ts_sel[15:3]) && !o_fault_new_ctx
        && o_fault_ip == $past(i_old_ip);
  endproperty
  a_short_record: assert property (p_short_record)
    else $error("short record not reported");

  property p_precommit_old;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (o_fault_valid && !o_fault_new_ctx) |-> $past(state_q) == ST_IDLE && !o_busy;
  endproperty
  a_precommit_old: assert property (p_precommit_old)
    else $error("old-context fault outside idle");

  property p_commit;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    o_committed |=> state_q == ST_LOAD && o_check_active;
  endproperty
  a_commit: assert property (p_commit)
    else $error("commit did not start loading");

  property p_post_commit_late;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (o_fault_valid && o_fault_new_ctx)
    |-> $past(i_seg_valid && i_seg_last && state_q == ST_LOAD)
        && o_fault_ip == new_ip_q;
  endproperty
  a_post_commit_late: assert property (p_post_commit_late)
    else $error("new-task fault before full load");

  property p_stop_checks;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == ST_LOAD && i_seg_valid && !i_seg_last && seg_viol != VIOL_NONE)
    |=> !o_check_active ##1 (!o_check_active || state_q != ST_LOAD);
  endproperty
  a_stop_checks: assert property (p_stop_checks)
    else $error("checking resumed after a violation");

  property p_gate_write;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    ld_take |-> (o_ld_write == (i_ld_kind != LD_GATE));
  endproperty
  a_gate_write: assert property (p_gate_write)
    else $error("load write wrong for gate or register");

  property p_stack_handoff;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (ld_take && ld_is_stack && !i_ld_present) |=> o_stack_handoff && !o_fault_valid;
  endproperty
  a_stack_handoff: assert property (p_stack_handoff)
    else $error("absent stack not handed off");

  property p_absent_code;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (ld_take && !ld_is_stack && !i_ld_present && !i_delivering)
    |=> o_fault_vector == VEC_SEG_ABSENT && o_fault_code[0] == $past(i_ld_ext)
        && o_fault_code[1] == $past(i_ld_idt) && o_fault_code[2] == $past(i_ld_sel[2]);
  endproperty
  a_absent_code: assert property (p_absent_code)
    else $error("absent fault code fields wrong");

  property p_double;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (raise_any && i_delivering && i_prior_class != CLS_BENIGN)
    |=> o_double_fault && o_fault_vector == VEC_DOUBLE && o_fault_code == CODE_RST;
  endproperty
  a_double: assert property (p_double)
    else $error("contributory fault not escalated");

endmodule

/* tb_task_switch_segment_fault_checker.sv */
// bench for the task-switch fault checker: single loads, switches, escalation
// assumes the design carries its own assertions; the bench drives every port
module tb_task_switch_segment_fault_checker;
  timeunit 1ns;
  timeprecision 1ps;
  import tsf_pkg::*;

  typedef struct {load_kind_e k; logic pres, external_event_flag, interrupt_vector_table, flt, hand, wr;} ld_row_s;
  typedef struct {seg_kind_e k; logic ovl, pres; logic [1:0] descriptor_privilege; logic [7:0] v;
                  logic hand;} sw_row_s;

  logic        i_core_clk, i_reset_n, i_ts_start, i_ts_present, i_ts_ext, i_ts_link_req;
  logic        i_tr_loaded, i_link_ok, i_seg_valid, i_seg_last, i_seg_over_limit;
  logic        i_seg_present, i_seg_table_ok, i_seg_writable, i_seg_readable, i_seg_exec;
  logic        i_seg_conforming, i_ld_valid, i_ld_present, i_ld_ext, i_ld_idt, i_delivering;
  logic [15:0] i_ts_sel, i_seg_sel, i_ld_sel, o_fault_code;
  logic [31:0] i_ts_limit, i_old_ip, i_new_ip, i_ld_ip, o_fault_ip;
  logic [1:0]  i_seg_dpl, i_cpl;
  logic [7:0]  o_fault_vector;
  seg_kind_e   i_seg_kind;
  load_kind_e  i_ld_kind;
  exc_class_e  i_prior_class;
  logic        o_fault_valid, o_fault_new_ctx, o_double_fault, o_stack_handoff, o_committed;
  logic        o_seg_load_en, o_check_active, o_ld_write, o_busy;
  int          err_total, comparisons;
  logic [15:0] sel;

  // ordinary single loads and switches, expected results beside the inputs
  ld_row_s ld_rows [7] = '{'{LD_CODE, 0, 1, 0, 1, 0, 1}, '{LD_DATA, 0, 0, 1, 1, 0, 1},
    '{LD_STACK, 0, 0, 0, 0, 1, 1}, '{LD_LOCAL_TABLE, 0, 1, 1, 1, 0, 1},
    '{LD_TASK_REG, 0, 0, 0, 1, 0, 1}, '{LD_GATE, 0, 0, 1, 1, 0, 0}, '{LD_DATA, 1, 0, 0, 0, 0, 1}};
  sw_row_s sw_rows [6] = '{'{SEG_LOCAL_TABLE, 0, 0, 0, VEC_INVALID_TASK, 0},
    '{SEG_CODE, 0, 1, 1, VEC_INVALID_TASK, 0}, '{SEG_DATA, 1, 1, 0, VEC_INVALID_TASK, 0},
    '{SEG_DATA, 0, 0, 0, VEC_SEG_ABSENT, 0}, '{SEG_STACK, 0, 0, 0, VEC_SEG_ABSENT, 1},
    '{SEG_STACK, 0, 1, 1, VEC_INVALID_TASK, 0}};

  task_switch_segment_fault_checker i_dut (.*);

  // core clock, 40 ns period
  initial
  begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  // error code worked out independently of the design's helper
  function automatic logic [15:0] ecode(input logic [15:0] s, input logic e, input logic d);
    return {s[15:3], s[2], d, e};
  endfunction

  task automatic step();
    @(posedge i_core_clk);
    #1;
  endtask

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic chk_fault(input logic [7:0] v, input logic [15:0] c, input logic [31:0] p,
                           input logic nc);
    chk_bit(o_fault_valid, 1'b1);
    chk_val(32'(o_fault_vector), 32'(v));
    chk_val(32'(o_fault_code), 32'(c));
    chk_val(o_fault_ip, p);
    chk_bit(o_fault_new_ctx, nc);
  endtask

  // single load or gate use; write enable is seen in the request cycle
  task automatic ld(input load_kind_e k, input logic [15:0] s, input logic p, input logic wr);
    i_ld_valid = 1'b1;
    i_ld_kind = k;
    i_ld_sel = s;
    i_ld_present = p;
    // let the combinational enable settle before looking at it
    #1;
    chk_bit(o_ld_write, wr);
    step();
    i_ld_valid = 1'b0;
  endtask

  // start a switch; the caller sets ext and link request first
  task automatic sw_start(input logic [15:0] s, input logic [31:0] lim, input logic p);
    i_ts_start = 1'b1;
    i_ts_sel = s;
    i_ts_limit = lim;
    i_ts_present = p;
    step();
    i_ts_start = 1'b0;
  endtask

  task automatic commit();
    i_tr_loaded = 1'b1;
    i_link_ok = 1'b1;
    #1;
    chk_bit(o_committed, 1'b1);
    step();
    i_tr_loaded = 1'b0;
    i_link_ok = 1'b0;
  endtask

  // one segment register from the record; code is the only executable kind
  task automatic seg(input seg_kind_e k, input logic [15:0] s, input logic ovl, input logic p,
                     input logic [1:0] descriptor_privilege, input logic last);
    i_seg_valid = 1'b1;
    i_seg_kind = k;
    i_seg_sel = s;
    i_seg_over_limit = ovl;
    i_seg_present = p;
    i_seg_dpl = descriptor_privilege;
    i_seg_exec = (k == SEG_CODE);
    i_seg_last = last;
    #1;
    chk_bit(o_seg_load_en, 1'b1);
    step();
    // valid stays up between back-to-back loads of one switch
    if (last)
    begin
      i_seg_valid = 1'b0;
      i_seg_last = 1'b0;
    end
  endtask

  // watchdog: the whole run takes well under 300 cycles
  initial
  begin
    repeat (3000) @(posedge i_core_clk);
    err_total++;
    test_done();
  end

  // main sequence
  initial
  begin
    {i_ts_start, i_ts_present, i_ts_ext, i_ts_link_req, i_tr_loaded, i_link_ok} = '0;
    {i_seg_valid, i_seg_last, i_seg_over_limit, i_seg_exec, i_seg_conforming} = '0;
    {i_ld_valid, i_ld_present, i_ld_ext, i_ld_idt, i_delivering, i_reset_n} = '0;
    {i_seg_present, i_seg_table_ok, i_seg_writable, i_seg_readable} = 4'hf;
    {i_ts_sel, i_seg_sel, i_ld_sel, i_seg_dpl, i_cpl} = '0;
    i_ts_limit = 32'h0000_0067;
    i_old_ip = 32'h0000_4000;
    i_new_ip = 32'h0000_8000;
    i_ld_ip = 32'h0000_1000;
    i_seg_kind = SEG_DATA;
    i_ld_kind = LD_CODE;
    i_prior_class = CLS_BENIGN;
    err_total = 0;
    comparisons = 0;
    repeat (20) step();
    i_reset_n = 1'b1;
    chk_val({o_fault_code, o_fault_vector, 7'h0, o_fault_valid}, 32'h0);
    chk_bit(o_busy, 1'b0);
    foreach (ld_rows[n])
    begin
      sel = 16'h0a5c ^ 16'(n << 3);
      i_ld_ext = ld_rows[n].external_event_flag;
      i_ld_idt = ld_rows[n].interrupt_vector_table;
      ld(ld_rows[n].k, sel, ld_rows[n].pres, ld_rows[n].wr);
      chk_bit(o_fault_valid, ld_rows[n].flt);
      chk_bit(o_stack_handoff, ld_rows[n].hand);
      if (ld_rows[n].flt)
        chk_fault(VEC_SEG_ABSENT, ecode(sel, i_ld_ext, i_ld_idt), i_ld_ip, 1'b0);
      step();
    end
    foreach (sw_rows[n])
    begin
      sel = 16'h0300 + 16'(n * 8);
      sw_start(16'h0200, 32'h0000_0067, 1'b1);
      commit();
      seg(sw_rows[n].k, sel, sw_rows[n].ovl, sw_rows[n].pres, sw_rows[n].descriptor_privilege, 1'b1);
      chk_bit(o_stack_handoff, sw_rows[n].hand);
      chk_bit(o_fault_valid, !sw_rows[n].hand);
      if (!sw_rows[n].hand)
        chk_fault(sw_rows[n].v, ecode(sel, 1'b0, 1'b0), i_new_ip, 1'b1);
      step();
    end
    // record limit one below the minimum, absent too: limit wins, old context
    i_ts_ext = 1'b1;
    sw_start(16'h0158, 32'h0000_0066, 1'b0);
    chk_fault(VEC_INVALID_TASK, ecode(16'h0158, 1'b1, 1'b0), i_old_ip, 1'b0);
    chk_bit(o_busy, 1'b0);
    step();
    i_ts_ext = 1'b0;
    sw_start(16'h0164, 32'h0000_0067, 1'b0);
    chk_fault(VEC_SEG_ABSENT, ecode(16'h0164, 1'b0, 1'b0), i_old_ip, 1'b0);
    step();
    // call switch: no commit without the link, loads refused while busy
    i_ts_link_req = 1'b1;
    sw_start(16'h0168, 32'h0000_0067, 1'b1);
    i_tr_loaded = 1'b1;
    ld(LD_CODE, 16'h0010, 1'b0, 1'b0);
    chk_bit(o_committed, 1'b0);
    chk_bit(o_fault_valid, 1'b0);
    commit();
    chk_bit(o_check_active, 1'b1);
    seg(SEG_STACK, 16'h0030, 1'b1, 1'b1, 2'h0, 1'b0);
    chk_bit(o_check_active, 1'b0);
    seg(SEG_CODE, 16'h0038, 1'b1, 1'b1, 2'h0, 1'b0);
    chk_bit(o_fault_valid, 1'b0);
    seg(SEG_DATA, 16'h0040, 1'b0, 1'b1, 2'h0, 1'b1);
    chk_fault(VEC_INVALID_TASK, ecode(16'h0030, 1'b0, 1'b0), i_new_ip, 1'b1);
    chk_bit(o_busy, 1'b0);
    i_ts_link_req = 1'b0;
    // reset in mid-switch abandons it
    sw_start(16'h0170, 32'h0000_0067, 1'b1);
    chk_bit(o_busy, 1'b1);
    i_reset_n = 1'b0;
    step();
    i_reset_n = 1'b1;
    chk_bit(o_busy, 1'b0);
    chk_bit(o_check_active, 1'b0);
    // absent fault while delivering each class of prior exception
    i_delivering = 1'b1;
    for (int c = 0; c < 3; c++)
    begin
      i_prior_class = exc_class_e'(2'(c));
      ld(LD_DATA, 16'h0048, 1'b0, 1'b1);
      chk_bit(o_double_fault, c != 0);
      chk_val(32'(o_fault_vector), 32'((c != 0) ? VEC_DOUBLE : VEC_SEG_ABSENT));
      chk_val(32'(o_fault_code),
              (c != 0) ? 32'h0 : 32'(ecode(16'h0048, i_ld_ext, i_ld_idt)));
      step();
    end
    test_done();
  end
endmodule
